// ===== hw/plcp_regs.vh
// Constants for the parallel LCD/camera port
`ifndef PLCP_REGS_VH
`define PLCP_REGS_VH
`define PLCP_LCD_W          24
`define PLCP_CAM_W          16
`define PLCP_DAC_W          8
`define PLCP_FIFO_W         24
`define PLCP_FIFO_DEPTH     8
`define PLCP_FIFO_AW        3
`define PLCP_CAM_FMT        3'h1
`define PLCP_ALMOST_EMPTY   4'h2
`define PLCP_ALMOST_FULL    4'h6
`define PLCP_HUNG_W         16
`define PLCP_HUNG_RST       16'h0100
`define PLCP_EV_N           16
`define PLCP_EV_TX_HUNG     0
`define PLCP_EV_RX_HUNG     1
`define PLCP_EV_TX_EMPTY    2
`define PLCP_EV_TX_FULL     3
`define PLCP_EV_RX_EMPTY    4
`define PLCP_EV_RX_FULL     5
`define PLCP_EV_TX_LOW      6
`define PLCP_EV_RX_HIGH     7
`define PLCP_EV_TX_ALLDONE  8
`define PLCP_EV_RX_NODSCR   9
`define PLCP_EV_TX_DSCRERR  10
`define PLCP_EV_RX_DSCRERR  11
`define PLCP_EV_TX_EOF      12
`define PLCP_EV_TX_DONE     13
`define PLCP_EV_RX_COMPLETE 14
`define PLCP_EV_RX_DONE     15
`endif

// ===== hw/plcp_fifo.v
// Synchronous FIFO with valid/ready on both sides
`default_nettype none
module plcp_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             clk_sys_in,
	input  wire             srst_in,
	// Fill side
	input  wire             wr_valid_in,
	output wire             wr_ready_out,
	input  wire [WIDTH-1:0] wr_data_in,
	// Drain side
	output wire             rd_valid_out,
	input  wire             rd_ready_in,
	output wire [WIDTH-1:0] rd_data_out,
	// Fill level
	output wire [AW:0]      level_out
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wptr_r;
	reg [AW-1:0]    rptr_r;
	reg [AW:0]      cnt_r;
	wire            push;
	wire            pop;

	assign wr_ready_out = (cnt_r != DEPTH[AW:0]);
	assign rd_valid_out = (cnt_r != {(AW+1){1'b0}});
	assign rd_data_out  = mem[rptr_r];
	assign level_out    = cnt_r;
	assign push = wr_valid_in & wr_ready_out;
	assign pop  = rd_valid_out & rd_ready_in;

	always @(posedge clk_sys_in)
	begin
		if (push)
		begin
			mem[wptr_r] <= wr_data_in;
		end
	end

	always @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			wptr_r <= {AW{1'b0}};
			rptr_r <= {AW{1'b0}};
			cnt_r  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop)
			begin
				rptr_r <= rptr_r + 1'b1;
			end
			if (push & ~pop)
			begin
				cnt_r <= cnt_r + 1'b1;
			end
			else if (pop & ~push)
			begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // plcp_fifo
`default_nettype wire

// ===== hw/plcp_port.v
// Parallel LCD / camera / converter port with event status
`include "plcp_regs.vh"
`default_nettype none
// How it works
// - Three variants: LCD transmit, camera receive, converter mode.
// - Strobe toggles once per bit-clock tick, so half its rate.
// - Converter mode runs the bit tick from the PLL half clock.
// - LCD pushes 24-bit words, strobe acts as panel write.
// - LCD mode when parallel enable set, tx follower and camera enable cleared.
// - Form 1 strobe doubling only; form 2 both doubling bits.
// - Camera takes 16-bit data with line, frame and valid qualifiers.
// - Camera pixel clock arrives on the strobe input.
// - Capture only while all three qualifiers are high.
// - Camera mode needs enables and rx follower set, rx order bits clear.
// - Camera needs rx channel and fifo formats equal to one.
// - ADC mode is master receive; strobe paces converter sampling.
// - Right data goes to right converter, left to left converter.
// - DAC right sample is upper byte, left sample lower byte of a 16-bit element.
// - DAC needs enable, sync and shift bits clear, tx follower clear.
// - DAC mode carries a 16-bit stream.
// - Separate transmit and receive timeout events.
// - Events for tx and rx FIFO empty and full.
// - Events for tx almost empty and rx almost full.
// - Events for tx lists exhausted and rx descriptors gone.
// - Separate tx and rx descriptor error events.
// - Events for tx eof, tx done, rx complete, rx descriptor done.
module plcp_port (
	// Clock and reset
	input  wire                       clk_sys_in,
	input  wire                       srst_in,
	// Configuration
	input  wire                       parallel_mode_enable_in,
	input  wire                       camera_enable_in,
	input  wire                       converter_enable_in,
	input  wire                       tx_follower_select_in,
	input  wire                       rx_follower_select_in,
	input  wire                       tx_data_doubling_in,
	input  wire                       tx_strobe_doubling_in,
	input  wire [2:0]                 tx_channel_format_in,
	input  wire [2:0]                 tx_fifo_format_in,
	input  wire [2:0]                 rx_channel_format_in,
	input  wire [2:0]                 rx_fifo_format_in,
	input  wire                       rx_msb_right_in,
	input  wire                       rx_right_first_in,
	input  wire                       tx_short_sync_in,
	input  wire                       rx_short_sync_in,
	input  wire                       tx_msb_shift_in,
	input  wire                       rx_msb_shift_in,
	input  wire                       tx_start_in,
	input  wire                       rx_start_in,
	input  wire [7:0]                 bit_clock_div_in,
	input  wire [`PLCP_HUNG_W-1:0]    hung_limit_in,
	// Clock ticks
	input  wire                       audio_tick_in,
	input  wire                       pll_half_clock_tick_in,
	// Transmit data from memory side
	input  wire                       tx_valid_in,
	output wire                       tx_ready_out,
	input  wire [`PLCP_FIFO_W-1:0]    tx_data_in,
	// Receive data to memory side
	output wire                       rx_valid_out,
	input  wire                       rx_ready_in,
	output wire [`PLCP_FIFO_W-1:0]    rx_data_out,
	// Parallel pins
	output reg  [`PLCP_LCD_W-1:0]     lcd_data_out,
	output reg                        strobe_out,
	input  wire                       strobe_in,
	input  wire [`PLCP_CAM_W-1:0]     parallel_data_input_in,
	input  wire                       line_sync_input_in,
	input  wire                       frame_sync_input_in,
	input  wire                       line_valid_input_in,
	input  wire [`PLCP_DAC_W-1:0]     adc_data_in,
	output reg  [`PLCP_DAC_W-1:0]     right_output_converter_out,
	output reg  [`PLCP_DAC_W-1:0]     left_output_converter_out,
	output wire                       adc_route_to_serial_unit_out,
	// Descriptor engine events
	input  wire                       tx_lists_exhausted_in,
	input  wire                       rx_no_descriptor_in,
	input  wire                       tx_descriptor_error_in,
	input  wire                       rx_descriptor_error_in,
	input  wire                       tx_packet_eof_in,
	input  wire                       rx_complete_in,
	input  wire                       rx_descriptor_done_in,
	// Status
	input  wire [`PLCP_EV_N-1:0]      event_enable_in,
	input  wire [`PLCP_EV_N-1:0]      event_clear_in,
	output reg  [`PLCP_EV_N-1:0]      event_raw_out,
	output wire [`PLCP_EV_N-1:0]      event_status_out,
	output wire [1:0]                 mode_out
);
	localparam [1:0] MODE_OFF = 2'h0;
	localparam [1:0] MODE_LCD = 2'h1;
	localparam [1:0] MODE_CAM = 2'h2;
	localparam [1:0] MODE_CNV = 2'h3;

	reg  [1:0]                mode_nxt;
	reg  [7:0]                div_r;
	reg                       tick_r;
	reg                       form2_phase_r;
	reg                       strobe_d_r;
	reg  [`PLCP_HUNG_W-1:0]   tx_idle_r;
	reg  [`PLCP_HUNG_W-1:0]   rx_idle_r;
	reg                       rx_push_r;
	reg  [`PLCP_FIFO_W-1:0]   rx_word_r;
	reg  [1:0]                mode_r;
	wire                      tx_fifo_valid;
	wire [`PLCP_FIFO_W-1:0]   tx_fifo_data;
	wire [`PLCP_FIFO_AW:0]    tx_level;
	wire [`PLCP_FIFO_AW:0]    rx_level;
	wire                      rx_fifo_ready;
	wire                      tx_pop;
	wire                      src_tick;
	wire                      pclk_rise;
	wire                      qual_ok;
	wire                      tx_run;
	wire                      rx_run;
	wire [`PLCP_EV_N-1:0]     ev_set;

	// Mode decode
	always @*
	begin
		mode_nxt = MODE_OFF;
		if (parallel_mode_enable_in)
		begin
			if (converter_enable_in && !tx_short_sync_in && !rx_short_sync_in
				&& !tx_msb_shift_in && !rx_msb_shift_in && !tx_follower_select_in
				&& !rx_follower_select_in)
				mode_nxt = MODE_CNV;
			else if (camera_enable_in && rx_follower_select_in && !rx_msb_right_in
				&& !rx_right_first_in && rx_channel_format_in == `PLCP_CAM_FMT
				&& rx_fifo_format_in == `PLCP_CAM_FMT)
				mode_nxt = MODE_CAM;
			else if (!tx_follower_select_in && !camera_enable_in)
				mode_nxt = MODE_LCD;
		end
	end
	assign mode_out = mode_r;

	// Converter mode paces from the PLL half clock
	assign src_tick = (mode_r == MODE_CNV) ? pll_half_clock_tick_in : audio_tick_in;

	assign tx_run = tx_start_in && (mode_r == MODE_LCD || mode_r == MODE_CNV);
	assign rx_run = rx_start_in && (mode_r == MODE_CAM || mode_r == MODE_CNV);

	// Form 2 holds a word for two strobes; form 1 only doubles the strobe
	assign tx_pop = tx_run && tick_r && strobe_out && tx_fifo_valid
		&& !(tx_data_doubling_in && tx_strobe_doubling_in && !form2_phase_r);

	// Camera: pixel clock edge on the strobe input, qualified by the three syncs
	assign pclk_rise = strobe_in & ~strobe_d_r;
	assign qual_ok = line_sync_input_in & frame_sync_input_in & line_valid_input_in;

	always @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			mode_r <= MODE_OFF;
			div_r <= 8'h00;
			tick_r <= 1'b0;
			strobe_out <= 1'b0;
			form2_phase_r <= 1'b0;
			strobe_d_r <= 1'b0;
			lcd_data_out <= {`PLCP_LCD_W{1'b0}};
			right_output_converter_out <= {`PLCP_DAC_W{1'b0}};
			left_output_converter_out <= {`PLCP_DAC_W{1'b0}};
			rx_push_r <= 1'b0;
			rx_word_r <= {`PLCP_FIFO_W{1'b0}};
		end
		else
		begin
			mode_r <= mode_nxt;
			strobe_d_r <= strobe_in;
			tick_r <= 1'b0;
			rx_push_r <= 1'b0;
			if (src_tick)
			begin
				if (div_r == bit_clock_div_in)
				begin
					div_r <= 8'h00;
					tick_r <= 1'b1;
				end
				else
					div_r <= div_r + 8'h01;
			end
			// Strobe toggles once per bit tick, giving half the bit rate
			if (tick_r && (tx_run || (mode_r == MODE_CNV && rx_run)))
			begin
				strobe_out <= ~strobe_out;
				if (strobe_out && tx_run)
					form2_phase_r <= ~form2_phase_r;
			end
			else if (!tx_run && !rx_run)
				strobe_out <= 1'b0;
			if (tx_pop)
			begin
				if (mode_r == MODE_LCD)
					lcd_data_out <= tx_fifo_data;
				else
				begin
					// Element holds right in [15:8], left in [7:0]
					right_output_converter_out <= tx_fifo_data[15:8];
					left_output_converter_out <= tx_fifo_data[7:0];
				end
			end
			if (rx_run && mode_r == MODE_CAM && pclk_rise && qual_ok && rx_fifo_ready)
			begin
				// One pixel per word, zero-extended in the low 16 bits
				rx_word_r <= {8'h00, parallel_data_input_in};
				rx_push_r <= 1'b1;
			end
			else if (rx_run && mode_r == MODE_CNV && tick_r && !strobe_out && rx_fifo_ready)
			begin
				rx_word_r <= {8'h00, adc_data_in, 8'h00};
				rx_push_r <= 1'b1;
			end
		end
	end
	assign adc_route_to_serial_unit_out = (mode_r == MODE_CNV) && rx_start_in;

	plcp_fifo #(
		.WIDTH (`PLCP_FIFO_W),
		.DEPTH (`PLCP_FIFO_DEPTH),
		.AW    (`PLCP_FIFO_AW)
	) u_tx_fifo (
		.clk_sys_in   (clk_sys_in),
		.srst_in      (srst_in),
		.wr_valid_in  (tx_valid_in),
		.wr_ready_out (tx_ready_out),
		.wr_data_in   (tx_data_in),
		.rd_valid_out (tx_fifo_valid),
		.rd_ready_in  (tx_pop),
		.rd_data_out  (tx_fifo_data),
		.level_out    (tx_level)
	);

	plcp_fifo #(
		.WIDTH (`PLCP_FIFO_W),
		.DEPTH (`PLCP_FIFO_DEPTH),
		.AW    (`PLCP_FIFO_AW)
	) u_rx_fifo (
		.clk_sys_in   (clk_sys_in),
		.srst_in      (srst_in),
		.wr_valid_in  (rx_push_r),
		.wr_ready_out (rx_fifo_ready),
		.wr_data_in   (rx_word_r),
		.rd_valid_out (rx_valid_out),
		.rd_ready_in  (rx_ready_in),
		.rd_data_out  (rx_data_out),
		.level_out    (rx_level)
	);

	// Timeouts: no progress while running for hung_limit cycles
	always @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			tx_idle_r <= {`PLCP_HUNG_W{1'b0}};
			rx_idle_r <= {`PLCP_HUNG_W{1'b0}};
		end
		else
		begin
			if (!tx_run || tx_pop || tx_idle_r == hung_limit_in)
				tx_idle_r <= {`PLCP_HUNG_W{1'b0}};
			else
				tx_idle_r <= tx_idle_r + 1'b1;
			if (!rx_run || rx_push_r || rx_idle_r == hung_limit_in)
				rx_idle_r <= {`PLCP_HUNG_W{1'b0}};
			else
				rx_idle_r <= rx_idle_r + 1'b1;
		end
	end

	assign ev_set[`PLCP_EV_TX_HUNG]     = tx_run && tx_idle_r == hung_limit_in;
	assign ev_set[`PLCP_EV_RX_HUNG]     = rx_run && rx_idle_r == hung_limit_in;
	assign ev_set[`PLCP_EV_TX_EMPTY]    = (tx_level == 4'h0);
	assign ev_set[`PLCP_EV_TX_FULL]     = (tx_level == 4'h8);
	assign ev_set[`PLCP_EV_RX_EMPTY]    = (rx_level == 4'h0);
	assign ev_set[`PLCP_EV_RX_FULL]     = (rx_level == 4'h8);
	assign ev_set[`PLCP_EV_TX_LOW]      = (tx_level <= `PLCP_ALMOST_EMPTY);
	assign ev_set[`PLCP_EV_RX_HIGH]     = (rx_level >= `PLCP_ALMOST_FULL);
	assign ev_set[`PLCP_EV_TX_ALLDONE]  = tx_lists_exhausted_in;
	assign ev_set[`PLCP_EV_RX_NODSCR]   = rx_no_descriptor_in;
	assign ev_set[`PLCP_EV_TX_DSCRERR]  = tx_descriptor_error_in;
	assign ev_set[`PLCP_EV_RX_DSCRERR]  = rx_descriptor_error_in;
	assign ev_set[`PLCP_EV_TX_EOF]      = tx_packet_eof_in;
	assign ev_set[`PLCP_EV_TX_DONE]     = tx_lists_exhausted_in && tx_level == 4'h0
		&& !tx_fifo_valid;
	assign ev_set[`PLCP_EV_RX_COMPLETE] = rx_complete_in;
	assign ev_set[`PLCP_EV_RX_DONE]     = rx_descriptor_done_in;

	// Set wins over a clear in the same cycle
	always @(posedge clk_sys_in)
	begin
		if (srst_in)
			event_raw_out <= {`PLCP_EV_N{1'b0}};
		else
			event_raw_out <= ev_set | (event_raw_out & ~event_clear_in);
	end
	assign event_status_out = event_raw_out & event_enable_in;
endmodule // plcp_port
`default_nettype wire

// ===== sim/plcp_port_props.sv
// Concurrent checks on the parallel LCD / camera port boundary
`include "plcp_regs.vh"
`default_nettype none
module plcp_port_props (
	// Clock and reset
	input wire logic                  clk_sys_in,
	input wire logic                  srst_in,
	// Configuration
	input wire logic                  parallel_mode_enable_in,
	input wire logic                  camera_enable_in,
	input wire logic                  converter_enable_in,
	input wire logic                  tx_follower_select_in,
	input wire logic                  rx_follower_select_in,
	input wire logic [2:0]            rx_channel_format_in,
	input wire logic [2:0]            rx_fifo_format_in,
	input wire logic                  rx_msb_right_in,
	input wire logic                  rx_right_first_in,
	input wire logic                  rx_start_in,
	input wire logic [7:0]            bit_clock_div_in,
	input wire logic                  pll_half_clock_tick_in,
	// Data paths
	input wire logic                  tx_valid_in,
	input wire logic                  tx_ready_out,
	input wire logic                  rx_valid_out,
	input wire logic                  strobe_out,
	input wire logic                  line_sync_input_in,
	input wire logic                  frame_sync_input_in,
	input wire logic                  line_valid_input_in,
	input wire logic                  adc_route_to_serial_unit_out,
	// Status
	input wire logic [`PLCP_EV_N-1:0] event_enable_in,
	input wire logic [`PLCP_EV_N-1:0] event_clear_in,
	input wire logic [`PLCP_EV_N-1:0] event_raw_out,
	input wire logic [`PLCP_EV_N-1:0] event_status_out,
	input wire logic [1:0]            mode_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	wire logic quals = line_sync_input_in & frame_sync_input_in & line_valid_input_in;
	sequence s_cam_push;
		$rose(rx_valid_out) && mode_out == 2'h2;
	endsequence
	sequence s_strobe_edge;
		$changed(strobe_out) && bit_clock_div_in != 8'h00;
	endsequence
	a_status_masked: assert property (
		event_status_out == (event_raw_out & event_enable_in))
		else $error("status differs from raw and enable");
	a_raw_sticky: assert property (
		(($past(event_raw_out) & ~$past(event_clear_in)) & ~event_raw_out) == 16'h0000)
		else $error("raw event dropped without clear");
	a_lcd_select: assert property (mode_out == 2'h1 |-> $past(parallel_mode_enable_in &&
		!tx_follower_select_in && !camera_enable_in && !converter_enable_in))
		else $error("lcd mode without its settings");
	a_cam_select: assert property (mode_out == 2'h2 |-> $past(parallel_mode_enable_in &&
		camera_enable_in && rx_follower_select_in && !rx_msb_right_in && !rx_right_first_in
		&& rx_channel_format_in == 3'h1 && rx_fifo_format_in == 3'h1))
		else $error("camera mode without its settings");
	a_strobe_half: assert property (s_strobe_edge |=> $stable(strobe_out) || !strobe_out)
		else $error("strobe toggled on consecutive cycles");
	a_tx_full_event: assert property (!tx_ready_out |=> event_raw_out[`PLCP_EV_TX_FULL])
		else $error("full fifo without full event");
	a_tx_ready_fall: assert property ($fell(tx_ready_out) |-> $past(tx_valid_in))
		else $error("fifo filled without a push");
	a_adc_route: assert property (
		adc_route_to_serial_unit_out |-> mode_out == 2'h3 && rx_start_in)
		else $error("adc routed outside converter receive");
	a_cam_gate: assert property (
		s_cam_push |-> $past(quals, 2) || $past(quals, 3) || $past(quals, 4))
		else $error("pixel captured without all qualifiers");
	a_pll_source: assert property ($changed(strobe_out) && mode_out == 2'h3 |->
		$past(pll_half_clock_tick_in) || $past(pll_half_clock_tick_in, 2)
		|| $past(pll_half_clock_tick_in, 3))
		else $error("converter strobe moved without pll tick");
endmodule // plcp_port_props
bind plcp_port plcp_port_props u_props (.*);
`default_nettype wire

// ===== sim/plcp_cam_model.sv
// Camera-side partner: pixel clock, pixel bus and sync qualifiers
`default_nettype none
module plcp_cam_model (
	// Clock
	input  wire logic        clk_sys_in,
	// Camera pins
	output var  logic        pclk_out,
	output var  logic [15:0] pixel_out,
	output var  logic [2:0]  quals_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		pclk_out = 1'b0;
		pixel_out = 16'h0000;
		quals_out = 3'h0;
	end
	// Slow pixel clock so the synchronous edge detector always sees it
	task automatic send(input logic [15:0] pix, input logic [2:0] q);
		@(negedge clk_sys_in);
		pixel_out = pix;
		quals_out = q;
		repeat (3) @(negedge clk_sys_in);
		pclk_out = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		pclk_out = 1'b0;
	endtask
	// Outside frames the clock stands still, qualifiers drop low and the bus toggles
	task automatic idle();
		@(negedge clk_sys_in);
		quals_out = 3'h0;
		pixel_out = ~pixel_out;
	endtask
endmodule // plcp_cam_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the parallel LCD / camera port
`include "plcp_regs.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in, srst_in, parallel_mode_enable_in, camera_enable_in, converter_enable_in;
	logic tx_follower_select_in, rx_follower_select_in, tx_data_doubling_in, tx_strobe_doubling_in;
	logic [2:0] tx_channel_format_in, tx_fifo_format_in, rx_channel_format_in, rx_fifo_format_in;
	logic rx_msb_right_in, rx_right_first_in, tx_short_sync_in, rx_short_sync_in, tx_msb_shift_in;
	logic rx_msb_shift_in, tx_start_in, rx_start_in, audio_tick_in, tx_valid_in, tx_ready_out;
	logic [7:0] bit_clock_div_in, adc_data_in, right_output_converter_out, left_output_converter_out;
	logic [15:0] hung_limit_in, event_enable_in, event_clear_in, event_raw_out, event_status_out;
	logic [23:0] tx_data_in, rx_data_out, lcd_data_out, lcd_last, w;
	logic rx_valid_out, rx_ready_in, strobe_out, adc_route_to_serial_unit_out, rx_cvt, lcd_on;
	logic tx_lists_exhausted_in, rx_no_descriptor_in, tx_descriptor_error_in;
	logic rx_descriptor_error_in, tx_packet_eof_in, rx_complete_in, rx_descriptor_done_in;
	logic [1:0] mode_out;
	logic pll_half_clock_tick_in = 1'b0;
	logic pll_on = 1'b0;
	logic [1:0] cyc = 2'h0;
	wire logic strobe_in, line_sync_input_in, frame_sync_input_in, line_valid_input_in;
	wire logic [15:0] parallel_data_input_in;
	wire logic [2:0] quals;
	int miscompares, n_compared, seed;
	int dma_bit[7] = '{8, 9, 10, 11, 12, 14, 15};
	logic [23:0] exp_q[$], cam_q[$];
	assign {line_sync_input_in, frame_sync_input_in, line_valid_input_in} = quals;
	plcp_port dut (.*);
	plcp_cam_model u_cam (.clk_sys_in(clk_sys_in), .pclk_out(strobe_in),
		.pixel_out(parallel_data_input_in), .quals_out(quals));
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// A wait that runs out ends the run at once
	task automatic bound(input logic ok);
		if (ok !== 1'b1)
		begin
			miscompares++;
			summarize();
		end
	endtask
	task automatic wait_raw(input int b);
		for (int i = 0; i < 200 && event_raw_out[b] !== 1'b1; i++)
			@(negedge clk_sys_in);
		bound(event_raw_out[b]);
	endtask
	initial
	begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end
	always @(negedge clk_sys_in)
	begin
		cyc <= cyc + 2'h1;
		pll_half_clock_tick_in <= pll_on && cyc == 2'h0;
	end
	// Drain side always ready, so each word is seen once at the falling edge
	always @(negedge clk_sys_in)
	begin
		if (lcd_on && lcd_data_out !== lcd_last && exp_q.size() > 0)
		begin
			check("lcd word", lcd_data_out, exp_q.pop_front());
			lcd_last = lcd_data_out;
		end
		if (rx_valid_out === 1'b1 && rx_ready_in)
			check("rx word", rx_data_out, rx_cvt ? {8'h00, adc_data_in, 8'h00} :
				(cam_q.size() > 0 ? cam_q.pop_front() : 24'hFFFFFF));
	end
	initial
	begin
		seed = 63;
		{parallel_mode_enable_in, camera_enable_in, converter_enable_in, tx_follower_select_in} = '0;
		{rx_follower_select_in, tx_data_doubling_in, rx_msb_right_in, rx_right_first_in} = '0;
		{tx_short_sync_in, rx_short_sync_in, tx_msb_shift_in, rx_msb_shift_in} = '0;
		{tx_start_in, rx_start_in, audio_tick_in, tx_valid_in, rx_cvt, lcd_on} = '0;
		{tx_channel_format_in, tx_fifo_format_in, rx_channel_format_in, rx_fifo_format_in} = '0;
		{rx_descriptor_done_in, rx_complete_in, tx_packet_eof_in, rx_descriptor_error_in} = '0;
		{tx_descriptor_error_in, rx_no_descriptor_in, tx_lists_exhausted_in} = '0;
		tx_strobe_doubling_in = 1'b1;
		rx_ready_in = 1'b1;
		bit_clock_div_in = 8'h01;
		hung_limit_in = 16'h0010;
		adc_data_in = 8'($random(seed));
		event_enable_in = 16'($random(seed));
		event_clear_in = 16'h0000;
		tx_data_in = 24'h000000;
		srst_in = 1'b1;
		repeat (12) @(negedge clk_sys_in);
		srst_in = 1'b0;
		parallel_mode_enable_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		check("lcd mode", mode_out, 2'h1);
		for (int f = 0; f < 2; f++)
		begin
			tx_data_doubling_in = f[0];
			event_clear_in = 16'hFFFF;
			for (int i = 0; i < 9; i++)
			begin
				tx_valid_in = 1'b1;
				tx_data_in = 24'($random(seed));
				if (tx_ready_out === 1'b1)
					exp_q.push_back(tx_data_in);
				@(negedge clk_sys_in);
			end
			// Clear held over the whole fill, since set wins while the FIFO is still low
			tx_valid_in = 1'b0;
			event_clear_in = 16'h0000;
			@(negedge clk_sys_in);
			check("tx ready when full", tx_ready_out, 1'b0);
			check("tx empty early", event_raw_out[`PLCP_EV_TX_EMPTY], 1'b0);
			check("tx low early", event_raw_out[`PLCP_EV_TX_LOW], 1'b0);
			check("tx full", event_raw_out[`PLCP_EV_TX_FULL], 1'b1);
			lcd_last = lcd_data_out;
			{lcd_on, tx_start_in, audio_tick_in} = 3'h7;
			for (int i = 0; i < 600 && exp_q.size() > 0; i++)
				@(negedge clk_sys_in);
			bound(exp_q.size() == 0);
			wait_raw(`PLCP_EV_TX_EMPTY);
			wait_raw(`PLCP_EV_TX_LOW);
			wait_raw(`PLCP_EV_TX_HUNG);
			{lcd_on, tx_start_in, audio_tick_in} = 3'h0;
		end
		for (int i = 0; i < 7; i++)
		begin
			{rx_descriptor_done_in, rx_complete_in, tx_packet_eof_in, rx_descriptor_error_in,
				tx_descriptor_error_in, rx_no_descriptor_in, tx_lists_exhausted_in} = 7'h01 << i;
			@(negedge clk_sys_in);
			{rx_descriptor_done_in, rx_complete_in, tx_packet_eof_in, rx_descriptor_error_in,
				tx_descriptor_error_in, rx_no_descriptor_in, tx_lists_exhausted_in} = 7'h00;
			@(negedge clk_sys_in);
			check("dma event held", event_raw_out[dma_bit[i]], 1'b1);
			check("status mask", event_status_out, event_raw_out & event_enable_in);
			if (i == 0)
			begin
				check("tx done", event_raw_out[`PLCP_EV_TX_DONE], 1'b1);
				check("strobe idle", strobe_out, 1'b0);
			end
			event_clear_in = 16'h0001 << dma_bit[i];
			@(negedge clk_sys_in);
			event_clear_in = 16'h0000;
			check("dma event cleared", event_raw_out[dma_bit[i]], 1'b0);
		end
		{camera_enable_in, rx_follower_select_in, rx_start_in} = 3'h7;
		{rx_channel_format_in, rx_fifo_format_in} = {3'h1, 3'h1};
		repeat (2) @(negedge clk_sys_in);
		check("camera mode", mode_out, 2'h2);
		for (int i = 0; i < 9; i++)
		begin
			w = {8'h00, 16'($random(seed))};
			if (i % 3 != 1)
				cam_q.push_back(w);
			u_cam.send(w[15:0], i % 3 != 1 ? 3'h7 : 3'h7 ^ (3'h1 << (i / 3)));
		end
		u_cam.idle();
		repeat (8) @(negedge clk_sys_in);
		check("pixels left", cam_q.size(), 24'h0);
		event_clear_in = 16'hFFFF;
		@(negedge clk_sys_in);
		event_clear_in = 16'h0000;
		wait_raw(`PLCP_EV_RX_HUNG);
		{camera_enable_in, rx_follower_select_in, converter_enable_in, tx_start_in} = 4'h3;
		{pll_on, rx_cvt} = 2'h3;
		repeat (2) @(negedge clk_sys_in);
		check("converter mode", mode_out, 2'h3);
		check("adc route", adc_route_to_serial_unit_out, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			w = 24'($random(seed));
			tx_valid_in = 1'b1;
			tx_data_in = w;
			@(negedge clk_sys_in);
			tx_valid_in = 1'b0;
			for (int k = 0; k < 300 && {right_output_converter_out,
				left_output_converter_out} !== w[15:0]; k++)
				@(negedge clk_sys_in);
			check("dac pair", {right_output_converter_out, left_output_converter_out}, w[15:0]);
		end
		summarize();
	end
endmodule // tb
`default_nettype wire
